// File: adc_conversion_sequencer.sv
// conversion sequencer: triggers, pairing, priority and results for one converter
//
// Operation
// (R01) sixteen channels, each fully configured
// (R02) pair bit zero: channels run independently
// (R03) pair bit one: even control drives both
// (R04) pair input select picks both muxes
// (R05) any mix of singles and pairs
// (R06) eight external start triggers accepted
// (R07) two internal starts from own interrupts
// (R08) per channel internal or external source
// (R09) trigger field picks external trigger
// (R10) one conversion at a time, others wait
// (R11) priority_control sets service order
// (R12) mux a chooses among six inputs
// (R13) mux b four inputs plus low reference
// (R14) two sample-and-hold units, captured together
// (R15) sampling window from channel control
// (R16) results readable by all; config separate
// (R17) completions mapped onto eight interrupts
// (R18) busy-time triggers held pending, not lost
`default_nettype none
module adc_conversion_sequencer (
   input  wire logic                                   clk,
   input  wire logic                                   resetn,
   input  wire adc_seq_pkg::channel_control_type [15:0] channel_control,
   input  wire logic [7:0]                             pair_mode_select,
   input  wire logic [15:0]                            internal_trigger_select_lo,
   input  wire logic [15:0]                            internal_trigger_select_hi,
   input  wire logic [1:0]                             priority_control,
   input  wire logic [15:0][2:0]                       interrupt_source_select,
   input  wire logic [15:0]                            irq_enable,
   input  wire logic [7:0]                             ext_trigger,
   input  wire logic [11:0]                            sample_a_data,
   input  wire logic [11:0]                            sample_b_data,
   output logic [15:0][11:0]                           conversion_result,
   output adc_seq_pkg::sample_request_type             sample_request,
   output logic                                        busy,
   output logic [15:0]                                 pending,
   output logic [7:0]                                  conversion_irq,
   output logic                                        conversion_irq_one,
   output logic                                        conversion_irq_two
);
   typedef enum {IDLE, SAMPLE, CONVERT} seq_state_type;

   seq_state_type                        state_q, state_d;      // sequencer state
   logic [15:0]                          pending_q, pending_d;  // held requests
   logic [3:0]                           chan_q, chan_d;        // channel in service
   logic                                 pair_q, pair_d;        // pair conversion
   logic [6:0]                           count_q, count_d;      // phase counter
   logic [3:0]                           last_q, last_d;        // last served
   logic [15:0][11:0]                    result_q, result_d;    // result file
   adc_seq_pkg::sample_request_type      req_q, req_d;          // front end request
   logic [7:0]                           irq_q, irq_d;          // eoc pulses
   logic                                 busy_q, busy_d;        // registered busy flag
   logic [15:0]                          trig_hit;              // starts this cycle
   logic                                 pick_found;            // some channel waits
   logic [3:0]                           pick_index;            // channel to serve next
   logic [15:0]                          eff_pending;           // pending as registered, unmasked
   logic [7:0]                           ext_q;                 // for edge detect

   // effective control: odd channel of a pair follows its even partner
   function automatic logic [3:0] ctl_owner(input logic [3:0] ch, input logic [7:0] pm);
      ctl_owner = (pm[ch[3:1]] && ch[0]) ? {ch[3:1], 1'b0} : ch;  // [R02] [R03]
   endfunction

   // source of a channel from the two select words
   function automatic logic [1:0] chan_source(input logic [3:0] ch);
      chan_source = {internal_trigger_select_hi[ch], internal_trigger_select_lo[ch]};
   endfunction

   // start detection per channel, rising edges for external triggers, interrupt level for internal starts
   // a level held high starts one conversion, not one per cycle
   genvar g;
   generate
      for (g = 0; g < 16; g++) begin : gen_trig
         logic [3:0] own;
         logic [1:0] src;
         logic [2:0] ts;
         assign own = ctl_owner(4'(g), pair_mode_select);  // [R05]
         assign src = chan_source(own);  // [R08]
         assign ts  = channel_control[own].trigger_select_field;
         // odd half of a pair never starts on its own
         assign trig_hit[g] = (own != 4'(g)) ? 1'b0 :
            (src == adc_seq_pkg::SRC_EXTERNAL) ? (ext_trigger[ts] && !ext_q[ts]) :  // [R06] [R09]
            (src == adc_seq_pkg::SRC_IRQ_ONE)  ? conversion_irq_one :  // [R07]
            (src == adc_seq_pkg::SRC_IRQ_TWO)  ? conversion_irq_two : 1'b0;
      end
   endgenerate

   // picker sees only registered requests: a trigger waits one cycle,
   // which keeps the picker off the raw trigger path
   assign eff_pending = pending_q;

   adc_priority_pick u_pick (
      .pending (eff_pending),
      .mode    (priority_control),
      .last    (last_q),
      .found   (pick_found),
      .index   (pick_index)
   );  // [R11]

   // pending bits are set before the pick clears one, so a new hit wins
   // sequencer next state
   always_comb begin
      logic [3:0] done_ch;
      done_ch   = 4'h0;
      state_d   = state_q;
      pending_d = pending_q | trig_hit;  // [R18]
      chan_d    = chan_q;
      pair_d    = pair_q;
      count_d   = count_q;
      last_d    = last_q;
      result_d  = result_q;
      req_d     = req_q;
      req_d.start = 1'b0;
      irq_d     = 8'h00;
      case (state_q)
         IDLE: begin
            if (pick_found) begin  // [R10]
               chan_d  = pick_index;
               pair_d  = pair_mode_select[pick_index[3:1]];  // [R03]
               pending_d[pick_index] = trig_hit[pick_index];  // a new hit stays set
               req_d.start = 1'b1;
               req_d.pair  = pair_mode_select[pick_index[3:1]];  // [R14]
               if (pair_mode_select[pick_index[3:1]]) begin
                  // pair code splits into one input per mux [R04]
                  req_d.mux_a = 3'(channel_control[pick_index].input_select_field[2:0] %
                                   3'(adc_seq_pkg::GROUP_A_INPUTS));  // [R12]
                  req_d.mux_b = 3'(channel_control[pick_index].input_select_field[2:0] %
                                   3'(adc_seq_pkg::GROUP_B_INPUTS));  // [R13]
               end else begin
                  // single: msb picks group b
                  if (channel_control[pick_index].input_select_field[3]) begin
                     req_d.mux_a = 3'h0;
                     req_d.mux_b = 3'(channel_control[pick_index].input_select_field[2:0] %
                                      3'(adc_seq_pkg::GROUP_B_INPUTS));  // [R13]
                  end else begin
                     req_d.mux_a = 3'(channel_control[pick_index].input_select_field[2:0] %
                                      3'(adc_seq_pkg::GROUP_A_INPUTS));  // [R12]
                     req_d.mux_b = adc_seq_pkg::LOW_REF_SEL;
                  end
               end
               // window never shorter than the analog minimum [R15]
               req_d.window = (channel_control[pick_index].window <
                               6'(adc_seq_pkg::WINDOW_MIN_CYCLES)) ?
                              6'(adc_seq_pkg::WINDOW_MIN_CYCLES) :
                              channel_control[pick_index].window;
               count_d = 7'h00;
               state_d = SAMPLE;
            end
         end
         SAMPLE: begin
            count_d = 7'(count_q + 7'h01);
            if (count_q == 7'(req_q.window - 6'h01)) begin  // [R15]
               count_d = 7'h00;
               state_d = CONVERT;
            end
         end
         CONVERT: begin
            count_d = 7'(count_q + 7'h01);
            if (count_q == 7'(adc_seq_pkg::CONVERT_CYCLES - 1)) begin
               result_d[chan_q] = sample_a_data;  // [R01] [R16]
               if (req_q.mux_a == 3'h0 && !pair_q &&
                   channel_control[chan_q].input_select_field[3])
                  result_d[chan_q] = sample_b_data;
               if (pair_q) begin
                  done_ch = {chan_q[3:1], 1'b1};
                  result_d[done_ch] = sample_b_data;  // [R04]
               end
               // route completions to interrupt lines [R17]
               if (irq_enable[chan_q])
                  irq_d[interrupt_source_select[chan_q]] = 1'b1;
               if (pair_q && irq_enable[done_ch])
                  irq_d[interrupt_source_select[done_ch]] = 1'b1;
               last_d  = chan_q;
               state_d = IDLE;
            end
         end
         default: state_d = IDLE;
      endcase
      // busy follows the next state so the output is a plain flop
      busy_d = (state_d != IDLE);
   end

   // sequencer registers
   // reset values are all constants; last served starts at the top channel
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q   <= IDLE;
         pending_q <= 16'h0000;
         chan_q    <= 4'h0;
         pair_q    <= 1'b0;
         count_q   <= 7'h00;
         last_q    <= 4'hF;
         result_q  <= '0;
         req_q     <= '0;
         irq_q     <= 8'h00;
         busy_q    <= 1'b0;
         ext_q     <= 8'h00;
      end else begin
         state_q   <= state_d;
         pending_q <= pending_d;
         chan_q    <= chan_d;
         pair_q    <= pair_d;
         count_q   <= count_d;
         last_q    <= last_d;
         result_q  <= result_d;
         req_q     <= req_d;
         irq_q     <= irq_d;
         busy_q    <= busy_d;
         ext_q     <= ext_trigger;
      end
   end

   // outputs straight from flops
   // busy is its own flop so no output carries decode logic
   assign conversion_result  = result_q;
   assign sample_request     = req_q;
   assign busy               = busy_q;
   assign pending            = pending_q;
   assign conversion_irq     = irq_q;
   assign conversion_irq_one = irq_q[0];  // [R07]
   assign conversion_irq_two = irq_q[1];

   // only one conversion in flight
   one_at_time_a: assert property (@(posedge clk) disable iff (!resetn)
      (state_q == IDLE && pick_found) |=> !req_d.start throughout (state_q != IDLE)[*2])
      else $error("second start while busy");  // [R10]

   sequence seq_start_s;
      state_q == IDLE && pick_found;
   endsequence
   start_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
      seq_start_s |=> req_q.start && state_q == SAMPLE)
      else $error("start pulse missing");  // [R15]
   window_min_a: assert property (@(posedge clk) disable iff (!resetn)
      req_q.start |-> req_q.window >= 6'(adc_seq_pkg::WINDOW_MIN_CYCLES))
      else $error("window below minimum");  // [R15]
   hold_pending_a: assert property (@(posedge clk) disable iff (!resetn)
      (busy && trig_hit != 16'h0000) |=> (pending_q & $past(trig_hit)) == $past(trig_hit))
      else $error("trigger lost while busy");  // [R18]
   odd_quiet_a: assert property (@(posedge clk) disable iff (!resetn)
      pair_mode_select[0] |-> !trig_hit[1])
      else $error("paired odd channel started");  // [R03]
   mux_a_range_a: assert property (@(posedge clk) disable iff (!resetn)
      req_q.mux_a < 3'(adc_seq_pkg::GROUP_A_INPUTS))
      else $error("mux a out of range");  // [R12]
   mux_b_range_a: assert property (@(posedge clk) disable iff (!resetn)
      req_q.mux_b < 3'(adc_seq_pkg::GROUP_B_INPUTS))
      else $error("mux b out of range");  // [R13]
   irq_at_end_a: assert property (@(posedge clk) disable iff (!resetn)
      irq_q != 8'h00 |-> $past(state_q) == CONVERT && state_q == IDLE)
      else $error("interrupt outside completion");  // [R17]
   pair_flag_a: assert property (@(posedge clk) disable iff (!resetn)
      req_q.start |-> req_q.pair == pair_mode_select[chan_q[3:1]] || $changed(pair_mode_select))
      else $error("pair flag mismatch");  // [R14]

   // phase counters never run past their ends
   sample_len_a: assert property (@(posedge clk) disable iff (!resetn)
      state_q == SAMPLE |-> count_q < 7'(req_q.window))
      else $error("sampling window overrun");  // [R15]
   convert_len_a: assert property (@(posedge clk) disable iff (!resetn)
      state_q == CONVERT |-> count_q < 7'(adc_seq_pkg::CONVERT_CYCLES))
      else $error("conversion overrun");  // [R10]

   // sampling hands over to conversion once the window is spent
   sequence seq_sample_end_s;
      state_q == SAMPLE && count_q == 7'(req_q.window - 6'h01);
   endsequence
   sequence seq_convert_begin_s;
      state_q == CONVERT && count_q == 7'h00;
   endsequence
   sample_to_convert_a: assert property (@(posedge clk) disable iff (!resetn)
      seq_sample_end_s |=> seq_convert_begin_s)
      else $error("conversion did not follow sampling");  // [R15]

   // busy flag follows the state register one for one
   busy_state_a: assert property (@(posedge clk) disable iff (!resetn)
      busy == (state_q != IDLE))
      else $error("busy flag out of step");  // [R10]
   // a start pulse never lasts two cycles
   start_once_a: assert property (@(posedge clk) disable iff (!resetn)
      req_q.start |=> !req_q.start)
      else $error("start pulse too long");  // [R10]

   // completion pulses last one cycle only
   irq_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
      irq_q != 8'h00 |=> irq_q == 8'h00)
      else $error("interrupt pulse too long");  // [R17]
   // results move only at the end of a conversion
   result_hold_a: assert property (@(posedge clk) disable iff (!resetn)
      state_q != CONVERT |=> $stable(result_q))
      else $error("result changed outside completion");  // [R16]

   // pair completion stores the group b sample in the odd result
   sequence seq_pair_done_s;
      irq_q != 8'h00 && pair_q;
   endsequence
   pair_odd_result_a: assert property (@(posedge clk) disable iff (!resetn)
      seq_pair_done_s |-> result_q[{chan_q[3:1], 1'b1}] == $past(sample_b_data))
      else $error("odd result of pair wrong");  // [R04]
endmodule
`default_nettype wire

// File: adc_front_end_model.sv
// behavioural analog front end answering the sequencer's sample requests
`default_nettype none
module adc_front_end_model (
   input  wire logic                            clk,
   input  wire adc_seq_pkg::sample_request_type sample_request,
   input  wire logic                            busy,
   output logic [11:0]                          sample_a_data,
   output logic [11:0]                          sample_b_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0]  held_a = 3'h0;    // mux a choice of the running conversion
   logic [2:0]  held_b = 3'h0;    // mux b choice of the running conversion
   logic [11:0] churn  = 12'h5A5; // known but meaningless idle pattern
   // both holds close on one start, so a pair is captured at one instant
   always @(posedge clk) begin
      if (sample_request.start) begin
         held_a <= sample_request.mux_a;
         held_b <= sample_request.mux_b;
      end
   end
   // idle data churns every cycle so a stale value never looks like a result
   always @(negedge clk) begin
      if (busy) begin
         sample_a_data <= 12'hA00 | {9'h000, held_a};
         sample_b_data <= (held_b == adc_seq_pkg::LOW_REF_SEL) ? 12'h000 :
                          (12'hB00 | {9'h000, held_b});
      end else begin
         churn         <= ~churn;
         sample_a_data <= churn;
         sample_b_data <= ~churn;
      end
   end
endmodule
`default_nettype wire

// File: adc_priority_pick.sv
// picks the next pending channel in priority order
`default_nettype none
module adc_priority_pick (
   input  wire logic [15:0] pending,
   input  wire logic [1:0]  mode,
   input  wire logic [3:0]  last,
   output logic             found,
   output logic [3:0]       index
);
   logic [4:0] k;  // loop offset
   logic [3:0] cand;  // candidate channel
   logic [3:0] base;  // search start

   // scan from base upward (or downward for fixed-high) and take first hit
   always_comb begin
      found = 1'b0;
      index = 4'h0;
      base  = (mode == adc_seq_pkg::PRIO_ROUND_ROBIN) ? 4'(last + 4'h1) : 4'h0;
      for (k = 5'h00; k < 5'h10; k = k + 5'h01) begin
         cand = (mode == adc_seq_pkg::PRIO_FIXED_HIGH) ? 4'(4'hF - k[3:0])
                                                       : 4'(base + k[3:0]);
         if (!found && pending[cand]) begin
            found = 1'b1;
            index = cand;
         end
      end
   end
endmodule
`default_nettype wire

// File: adc_seq_pkg.sv
// shared constants and carrier types for the conversion sequencer
`default_nettype none
package adc_seq_pkg;
   localparam int NUM_CHANNELS    = 16;  // programmable conversion channels
   localparam int NUM_PAIRS       = 8;   // even/odd pairs
   localparam int NUM_EXT_TRIG    = 8;   // external start triggers
   localparam int NUM_IRQ         = 8;   // end-of-conversion interrupt outputs
   localparam int RESULT_WIDTH    = 12;  // bits per conversion
   localparam int INPUT_SEL_WIDTH = 4;   // input_select_field width
   localparam int TRIG_SEL_WIDTH  = 3;   // trigger_select_field width
   localparam int WINDOW_WIDTH    = 6;   // sampling window field width
   localparam int IRQ_SEL_WIDTH   = 3;   // interrupt_source_select width
   localparam int GROUP_A_INPUTS  = 6;   // mux a choices
   localparam int GROUP_B_INPUTS  = 5;   // mux b choices, last is low reference
   localparam logic [2:0] LOW_REF_SEL = 3'h4;  // mux b code of low_reference_input
   localparam int WINDOW_MIN_CYCLES = 7; // least sampling window in clocks
   localparam int CONVERT_CYCLES  = 13;  // conversion time after sampling
   localparam logic [1:0] SRC_EXTERNAL = 2'h0;  // per-channel source codes
   localparam logic [1:0] SRC_IRQ_ONE  = 2'h1;
   localparam logic [1:0] SRC_IRQ_TWO  = 2'h2;
   localparam logic [1:0] PRIO_ROUND_ROBIN = 2'h0;  // priority_control modes
   localparam logic [1:0] PRIO_FIXED_LOW   = 2'h1;
   localparam logic [1:0] PRIO_FIXED_HIGH  = 2'h2;

   // one channel_control register
   typedef struct packed {
      logic [INPUT_SEL_WIDTH-1:0] input_select_field;
      logic [TRIG_SEL_WIDTH-1:0]  trigger_select_field;
      logic [WINDOW_WIDTH-1:0]    window;
   } channel_control_type;

   // request towards the analog front end
   typedef struct packed {
      logic                       start;
      logic                       pair;
      logic [2:0]                 mux_a;
      logic [2:0]                 mux_b;
      logic [WINDOW_WIDTH-1:0]    window;
   } sample_request_type;
endpackage
`default_nettype wire

// File: tb_adc_conversion_sequencer.sv
// self-checking bench for the conversion sequencer
`default_nettype none
module tb_adc_conversion_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   logic                                  clk = 1'b0;
   logic                                  resetn = 1'b0;
   adc_seq_pkg::channel_control_type [15:0] channel_control = '0;
   logic [7:0]                            pair_mode_select = 8'h00;
   logic [15:0]                           internal_trigger_select_lo = 16'hFFFF;  // all idle
   logic [15:0]                           internal_trigger_select_hi = 16'hFFFF;
   logic [1:0]                            priority_control = 2'h0;
   logic [15:0][2:0]                      interrupt_source_select;
   logic [7:0]                            ext_trigger = 8'h00;
   logic [15:0]                           irq_enable = 16'hFFDF;  // channel 5 masked
   logic [11:0]                           sample_a_data;
   logic [11:0]                           sample_b_data;
   logic [15:0][11:0]                     conversion_result;
   adc_seq_pkg::sample_request_type       sample_request;
   logic                                  busy;
   logic [15:0]                           pending;
   logic [7:0]                            conversion_irq;
   logic                                  conversion_irq_one;
   logic                                  conversion_irq_two;
   int                                    fail_count = 0;
   int                                    checks_done = 0;
   logic [31:0]                           seed = 32'h84B8;
   logic [3:0]                            sel;
   // each channel reports on line channel mod 8
   initial begin
      for (int c = 0; c < 16; c++) begin
         interrupt_source_select[c] = 3'(c);
      end
   end
   always #20 clk = ~clk;
   adc_conversion_sequencer i_dut (
      .clk(clk), .resetn(resetn), .channel_control(channel_control),
      .pair_mode_select(pair_mode_select),
      .internal_trigger_select_lo(internal_trigger_select_lo),
      .internal_trigger_select_hi(internal_trigger_select_hi),
      .priority_control(priority_control), .interrupt_source_select(interrupt_source_select),
      .irq_enable(irq_enable), .ext_trigger(ext_trigger), .sample_a_data(sample_a_data),
      .sample_b_data(sample_b_data), .conversion_result(conversion_result),
      .sample_request(sample_request), .busy(busy), .pending(pending),
      .conversion_irq(conversion_irq), .conversion_irq_one(conversion_irq_one),
      .conversion_irq_two(conversion_irq_two));
   adc_front_end_model i_front (
      .clk(clk), .sample_request(sample_request), .busy(busy),
      .sample_a_data(sample_a_data), .sample_b_data(sample_b_data));
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // result a single channel should hold for a given input select
   function automatic logic [11:0] exp_single(input logic [3:0] s);
      logic [2:0] b;
      b = 3'(s[2:0] % adc_seq_pkg::GROUP_B_INPUTS);
      if (!s[3]) return 12'hA00 | 12'(s[2:0] % adc_seq_pkg::GROUP_A_INPUTS);
      return (b == adc_seq_pkg::LOW_REF_SEL) ? 12'h000 : (12'hB00 | 12'(b));
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // configure one channel: source code, input select, trigger, window
   task automatic setch(input int ch, input logic [1:0] src, input logic [3:0] s,
                        input logic [2:0] trg, input logic [5:0] win);
      @(posedge clk);
      channel_control[ch] <= '{s, trg, win};
      internal_trigger_select_hi[ch] <= src[1];
      internal_trigger_select_lo[ch] <= src[0];
   endtask
   task automatic fire(input int t);
      @(posedge clk);
      ext_trigger[t] <= 1'b1;
      @(posedge clk);
      ext_trigger[t] <= 1'b0;
   endtask
   // follow one conversion from its start pulse to its completion pulse
   task automatic conv(input int ch, input logic pr, input logic [11:0] ea,
                       input logic [11:0] eb);
      int n;
      int w;
      logic [2:0] line;
      n = 0;
      w = (channel_control[ch].window < adc_seq_pkg::WINDOW_MIN_CYCLES) ?
          adc_seq_pkg::WINDOW_MIN_CYCLES : int'(channel_control[ch].window);
      line = interrupt_source_select[ch];
      while (sample_request.start !== 1'b1 && n < 60) begin
         @(negedge clk);
         n++;
      end
      check(busy, 1'b1);
      check(sample_request.pair, pr);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (conversion_irq[line] !== 1'b1 && n < 200);
      check(16'(n), 16'(w + adc_seq_pkg::CONVERT_CYCLES));
      check(conversion_result[ch], ea);
      if (pr) check(conversion_result[ch + 1], eb);
   endtask
   // main sequence
   initial begin
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      @(negedge clk);
      check(pending, 16'h0000);
      // every external trigger, each on its own even channel, random setup
      for (int t = 0; t < 8; t++) begin
         seed = lfsr_next(seed);
         sel = (t == 0) ? 4'hC : seed[3:0];     // first pass hits the low reference
         setch(2 * t, adc_seq_pkg::SRC_EXTERNAL, sel, 3'(t), seed[9:4]);
         fire(t);
         conv(2 * t, 1'b0, exp_single(sel), 12'h000);
         setch(2 * t, 2'h3, sel, 3'(t), seed[9:4]);
      end
      $display("external trigger test done");
      // two channels pend together; fixed-low serves 3 first, fixed-high and round robin serve 9 first
      setch(3, adc_seq_pkg::SRC_EXTERNAL, 4'h3, 3'h5, 6'h08);
      setch(9, adc_seq_pkg::SRC_EXTERNAL, 4'h9, 3'h5, 6'h08);
      for (int m = 0; m < 3; m++) begin
         @(posedge clk);
         priority_control <= (m == 0) ? adc_seq_pkg::PRIO_FIXED_LOW :
                             (m == 1) ? adc_seq_pkg::PRIO_FIXED_HIGH :
                             adc_seq_pkg::PRIO_ROUND_ROBIN;
         fire(5);
         conv((m == 0) ? 3 : 9, 1'b0, exp_single((m == 0) ? 4'h3 : 4'h9), 12'h000);
         check(pending[(m == 0) ? 9 : 3], 1'b1);
         conv((m == 0) ? 9 : 3, 1'b0, exp_single((m == 0) ? 4'h9 : 4'h3), 12'h000);
      end
      setch(3, 2'h3, 4'h3, 3'h5, 6'h08);
      setch(9, 2'h3, 4'h9, 3'h5, 6'h08);
      $display("priority test done");
      // pair 4/5: odd control ignored, even control drives both holds
      setch(4, adc_seq_pkg::SRC_EXTERNAL, 4'h5, 3'h2, 6'h00);
      pair_mode_select <= 8'h04;
      setch(5, adc_seq_pkg::SRC_EXTERNAL, 4'h1, 3'h6, 6'h3F);
      fire(6);
      repeat (3) @(negedge clk);
      check(pending, 16'h0000);
      fire(2);
      conv(4, 1'b1, 12'hA05, 12'hB00);
      check(conversion_irq, 8'h10);
      setch(4, 2'h3, 4'h5, 3'h2, 6'h00);
      $display("pair test done");
      // internal starts from both completion interrupts, pair still set
      for (int k = 0; k < 2; k++) begin
         setch(k ? 1 : 8, adc_seq_pkg::SRC_EXTERNAL, 4'h3, 3'h7, 6'h10);
         setch(k ? 10 : 6, k ? adc_seq_pkg::SRC_IRQ_TWO : adc_seq_pkg::SRC_IRQ_ONE,
               4'hE, 3'h0, 6'h07);
         fire(7);
         conv(k ? 1 : 8, 1'b0, exp_single(4'h3), 12'h000);
         check(k ? conversion_irq_two : conversion_irq_one, 1'b1);
         conv(k ? 10 : 6, 1'b0, exp_single(4'hE), 12'h000);
         setch(k ? 1 : 8, 2'h3, 4'h3, 3'h7, 6'h10);
         setch(k ? 10 : 6, 2'h3, 4'hE, 3'h0, 6'h07);
      end
      $display("internal trigger test done");
      conclude();
   end
   // watchdog, well past the expected run length
   initial begin
      #800000;
      fail_count++;
      $display("[FAIL] %0t ns: watchdog expired", $time);
      conclude();
   end
endmodule
`default_nettype wire
